/* hdl/anm_pkg.sv */
// Constants for the auto-negotiation next page message formatter.
// Assumes a single clock domain and 16-bit link code words.
package anm_pkg;
    // ==========================================================
    // Code word layout
    localparam int WORD_W = 16;
    localparam int CODE_W = 11;
    localparam int SEL_W = 5;
    localparam int POS_NEXT_PAGE = 15;
    localparam int POS_MESSAGE = 13;
    localparam int POS_TOGGLE = 11;
    // ==========================================================
    // Selector values (only the Ethernet one is allocated here)
    localparam logic [4:0] SEL_ETHERNET = 5'h01;
    // ==========================================================
    // Message codes
    localparam logic [10:0] MSG_NULL = 11'h001;
    localparam logic [10:0] MSG_REMOTE_FAULT = 11'h004;
    localparam logic [10:0] MSG_ORG_ID = 11'h005;
    localparam logic [10:0] MSG_PHY_ID = 11'h006;
    localparam logic [10:0] MSG_RESV_ZERO = 11'h000;
    localparam logic [10:0] MSG_RESV_ONES = 11'h7ff;
    // Highest message code treated as allocated
    localparam logic [10:0] MSG_MAX_ALLOC = 11'h00a;
    // ==========================================================
    // Technology priority table (Ethernet selector), highest first
    localparam int TECH_N = 5;
    localparam logic [2:0] TECH_NONE = 3'h7;
    // ==========================================================
    // Formatter states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_MSG = 3'b001,
        ST_UNF = 3'b010,
        ST_NULL = 3'b011
    } anm_state_t;
endpackage

/* hdl/anm_tech_resolve.sv */
// Priority resolution of common technologies under the Ethernet selector.
// Assumes ability bits ordered as in the base page technology field.
module anm_tech_resolve (
    // Abilities
    input wire logic [4:0] localAbility,
    input wire logic [4:0] partnerAbility,
    // Result
    output logic [2:0] bestTech,
    output logic bestValid
);
    // ==========================================================
    // Fixed order: index 4 is highest; inserting a technology shifts lower ones down
    logic [4:0] common;
    always_comb begin
        common = localAbility & partnerAbility;
        bestTech = anm_pkg::TECH_NONE;
        bestValid = 1'b0;
        for (int i = 0; i < anm_pkg::TECH_N; i++) begin
            if (common[i]) begin // Later (higher) index overrides
                bestTech = 3'(i);
                bestValid = 1'b1;
            end
        end
    end
endmodule

/* hdl/anm_formatter.sv */
// Auto-negotiation base page and next page message formatter and checker.
// Assumes the page exchange machine pulses pageAck per accepted page.
module anm_formatter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Base page request
    input wire logic [4:0] baseSelector,
    input wire logic [10:0] baseAbility,
    output logic baseSelectorOk,
    output logic [15:0] basePage,
    // Message request
    input wire logic msgReq,
    input wire logic [10:0] msgCode,
    input wire logic [10:0] faultCode,
    input wire logic [23:0] orgId,
    input wire logic [31:0] phyId,
    input wire logic [8:0] userCodeLow,
    input wire logic [10:0] userCodeExtra,
    input wire logic userCodeBit,
    input wire logic moreAfter,
    output logic msgReady,
    output logic msgRejected,
    // Exchange status
    input wire logic partnerPending,
    input wire logic pageAck,
    // Transmit page
    output logic txValid,
    output logic [15:0] txPage,
    // Receive check
    input wire logic [15:0] rxPage,
    input wire logic rxValid,
    output logic rxBadCode,
    output logic [1:0] rxUnfExpect,
    // Technology resolution
    input wire logic [4:0] localTech,
    input wire logic [4:0] partnerTech,
    output logic [2:0] bestTech,
    output logic bestValid
);
    // ==========================================================
    // Code checks
    function automatic logic selOk(input logic [4:0] s);
        selOk = (s == anm_pkg::SEL_ETHERNET); // Others reserved
    endfunction

    function automatic logic codeOk(input logic [10:0] c);
        codeOk = (c != anm_pkg::MSG_RESV_ZERO)
            && (c != anm_pkg::MSG_RESV_ONES)
            && (c <= anm_pkg::MSG_MAX_ALLOC);
    endfunction

    // Number of unformatted pages a message code implies
    function automatic logic [2:0] unfCount(input logic [10:0] c);
        unique case (c)
            anm_pkg::MSG_REMOTE_FAULT: unfCount = 3'h1;
            anm_pkg::MSG_ORG_ID: unfCount = 3'h4;
            anm_pkg::MSG_PHY_ID: unfCount = 3'h4;
            default: unfCount = 3'h0;
        endcase
    endfunction

    // ==========================================================
    // Base page: selector gated so a reserved value never goes out
    always_comb begin
        baseSelectorOk = selOk(baseSelector); // Selector names the base message
        basePage = {baseAbility, baseSelectorOk ? baseSelector : anm_pkg::SEL_ETHERNET};
    end

    // ==========================================================
    // Transmit sequencer
    anm_pkg::anm_state_t state_q, state_d;
    logic [10:0] code_q, code_d;
    logic [2:0] left_q, left_d;
    logic [2:0] idx_q, idx_d;
    logic [15:0] page_q, page_d;
    logic more_q, more_d;
    logic toggle_q, toggle_d;
    logic rej_q, rej_d;
    logic [10:0] fault_q, fault_d;
    logic [23:0] org_q, org_d;
    logic [31:0] phy_q, phy_d;
    logic [8:0] ulow_q, ulow_d;
    logic [10:0] uext_q, uext_d;
    logic ubit_q, ubit_d;

    // Unformatted field for the current page of the held message
    function automatic logic [10:0] unfField(input logic [10:0] c, input logic [2:0] i,
            input logic [10:0] f, input logic [23:0] o, input logic [31:0] p,
            input logic [8:0] ul, input logic [10:0] ux, input logic ub);
        unfField = ux;
        if (c == anm_pkg::MSG_REMOTE_FAULT) begin
            unfField = f;
        end else if (c == anm_pkg::MSG_ORG_ID) begin
            unique case (i)
                3'h0: unfField = o[23:13];
                3'h1: unfField = o[12:2];
                3'h2: unfField = {o[1:0], ul};
                default: unfField = ux;
            endcase
        end else if (c == anm_pkg::MSG_PHY_ID) begin
            unique case (i)
                3'h0: unfField = p[31:21]; // Register 2 bits 15:5
                3'h1: unfField = {p[20:16], p[15:10]};
                3'h2: unfField = {p[9:0], ub};
                default: unfField = ux;
            endcase
        end
    endfunction

    function automatic logic [15:0] mkPage(input logic more, input logic msg,
            input logic tog, input logic [10:0] field);
        mkPage = {more, 1'b0, msg, 1'b0, tog, field};
    endfunction

    // Next state; a new message is taken only from idle, so pages never interleave
    always_comb begin
        state_d = state_q;
        code_d = code_q;
        left_d = left_q;
        idx_d = idx_q;
        page_d = page_q;
        more_d = more_q;
        toggle_d = toggle_q;
        rej_d = 1'b0;
        fault_d = fault_q;
        org_d = org_q;
        phy_d = phy_q;
        ulow_d = ulow_q;
        uext_d = uext_q;
        ubit_d = ubit_q;
        unique case (state_q)
            anm_pkg::ST_IDLE: begin
                if (msgReq && !codeOk(msgCode)) begin
                    rej_d = 1'b1;
                end else if (msgReq) begin
                    code_d = msgCode;
                    left_d = unfCount(msgCode);
                    idx_d = 3'h0;
                    more_d = moreAfter;
                    fault_d = faultCode;
                    org_d = orgId;
                    phy_d = phyId;
                    ulow_d = userCodeLow;
                    uext_d = userCodeExtra;
                    ubit_d = userCodeBit;
                    page_d = mkPage((unfCount(msgCode) != 3'h0) || moreAfter, 1'b1,
                        toggle_q, msgCode);
                    state_d = anm_pkg::ST_MSG;
                end else if (partnerPending) begin
                    page_d = mkPage(1'b0, 1'b1, toggle_q, anm_pkg::MSG_NULL);
                    state_d = anm_pkg::ST_NULL;
                end
            end
            anm_pkg::ST_MSG, anm_pkg::ST_UNF: begin
                if (pageAck) begin // Advance strictly on acknowledge
                    toggle_d = !toggle_q;
                    if (left_q == 3'h0) begin
                        state_d = anm_pkg::ST_IDLE;
                    end else begin
                        page_d = mkPage((left_q != 3'h1) || more_q, 1'b0, !toggle_q,
                            unfField(code_q, idx_q, fault_q, org_q, phy_q, ulow_q,
                                uext_q, ubit_q));
                        left_d = left_q - 3'h1;
                        idx_d = idx_q + 3'h1;
                        state_d = anm_pkg::ST_UNF;
                    end
                end
            end
            anm_pkg::ST_NULL: begin
                if (pageAck) begin
                    toggle_d = !toggle_q;
                    state_d = anm_pkg::ST_IDLE;
                end
            end
            default: state_d = anm_pkg::ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= anm_pkg::ST_IDLE;
            code_q <= 11'h000;
            left_q <= 3'h0;
            idx_q <= 3'h0;
            page_q <= 16'h0000;
            more_q <= 1'b0;
            toggle_q <= 1'b0;
            rej_q <= 1'b0;
            fault_q <= 11'h000;
            org_q <= 24'h000000;
            phy_q <= 32'h00000000;
            ulow_q <= 9'h000;
            uext_q <= 11'h000;
            ubit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            code_q <= code_d;
            left_q <= left_d;
            idx_q <= idx_d;
            page_q <= page_d;
            more_q <= more_d;
            toggle_q <= toggle_d;
            rej_q <= rej_d;
            fault_q <= fault_d;
            org_q <= org_d;
            phy_q <= phy_d;
            ulow_q <= ulow_d;
            uext_q <= uext_d;
            ubit_q <= ubit_d;
        end
    end

    // Transmit outputs
    always_comb begin
        msgReady = (state_q == anm_pkg::ST_IDLE);
        txValid = (state_q != anm_pkg::ST_IDLE);
        txPage = page_q;
        msgRejected = rej_q;
    end

    // ==========================================================
    // Receive check: flag reserved codes, track expected unformatted pages
    logic rxBad_q, rxBad_d;
    logic [2:0] rxLeft_q, rxLeft_d;
    always_comb begin
        rxBad_d = 1'b0;
        rxLeft_d = rxLeft_q;
        if (rxValid && rxPage[anm_pkg::POS_MESSAGE]) begin
            rxBad_d = !codeOk(rxPage[10:0]);
            rxLeft_d = unfCount(rxPage[10:0]); // Code sets how pages read
        end else if (rxValid && (rxLeft_q != 3'h0)) begin
            rxLeft_d = rxLeft_q - 3'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxBad_q <= 1'b0;
            rxLeft_q <= 3'h0;
        end else begin
            rxBad_q <= rxBad_d;
            rxLeft_q <= rxLeft_d;
        end
    end

    assign rxBadCode = rxBad_q;
    // Two-bit view saturates: four pending pages show as three
    assign rxUnfExpect = rxLeft_q[2] ? 2'h3 : rxLeft_q[1:0];

    // ==========================================================
    // Technology priority (combinational, one table)
    anm_tech_resolve u_resolve (
        .localAbility(localTech),
        .partnerAbility(partnerTech),
        .bestTech(bestTech),
        .bestValid(bestValid)
    );
endmodule

/* tb/anm_checker.sv */
// Port-level assertions for the next page message formatter.
// Assumes one clock domain, rst asynchronous and active high.
module anm_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Base page and technology
    input wire logic [4:0] baseSelector,
    input wire logic [10:0] baseAbility,
    input wire logic baseSelectorOk,
    input wire logic [15:0] basePage,
    input wire logic [4:0] localTech,
    input wire logic [4:0] partnerTech,
    input wire logic [2:0] bestTech,
    input wire logic bestValid,
    // Message exchange
    input wire logic msgReq,
    input wire logic [10:0] msgCode,
    input wire logic msgReady,
    input wire logic msgRejected,
    input wire logic partnerPending,
    input wire logic pageAck,
    input wire logic txValid,
    input wire logic [15:0] txPage
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_sel_flag: assert property (baseSelectorOk == (baseSelector == 5'h01))
        else $error("selector flag wrong");
    a_base_sel: assert property (basePage == {baseAbility, 5'h01})
        else $error("base page selector not allocated");
    a_reject_bad: assert property (msgReq && msgReady && (msgCode == 11'h000
        || msgCode == 11'h7ff || msgCode > 11'h00a) |=> msgRejected && !txValid)
        else $error("bad code not refused");
    a_no_zero: assert property (txValid && txPage[13] |-> txPage[10:0] != 11'h000)
        else $error("zero code sent");
    a_no_ones: assert property (txValid && txPage[13] |-> txPage[10:0] != 11'h7ff)
        else $error("all ones code sent");
    a_code_alloc: assert property (txValid && txPage[13] |-> txPage[10:0] <= 11'h00a)
        else $error("unallocated code sent");
    a_busy_ignore: assert property (!msgReady |=> !msgRejected)
        else $error("request judged while busy");
    a_null_sent: assert property (msgReady && !msgReq && partnerPending |=>
        txValid && txPage[13] && txPage[10:0] == 11'h001) else $error("null page missing");
    a_page_hold: assert property (txValid && !pageAck |=> txValid && $stable(txPage))
        else $error("page changed before ack");
    a_toggle_step: assert property (txValid && pageAck ##1 txValid |->
        txPage[11] != $past(txPage[11])) else $error("toggle did not flip");
    a_fault_follow: assert property (txValid && pageAck && txPage[13]
        && txPage[10:0] == 11'h004 |=> txValid && !txPage[13]) else $error("fault page missing");
    a_tech_pick: assert property (bestValid |-> bestTech < 3'h5
        && ((localTech & partnerTech) >> bestTech) == 5'h01) else $error("wrong best tech");
    a_tech_none: assert property (!bestValid |-> (localTech & partnerTech) == 5'h00
        && bestTech == 3'h7) else $error("common tech missed");
endmodule

bind anm_formatter anm_checker i_anm_checker (.clk(clk), .rst(rst),
    .baseSelector(baseSelector), .baseAbility(baseAbility), .baseSelectorOk(baseSelectorOk),
    .basePage(basePage), .localTech(localTech), .partnerTech(partnerTech),
    .bestTech(bestTech), .bestValid(bestValid), .msgReq(msgReq), .msgCode(msgCode),
    .msgReady(msgReady), .msgRejected(msgRejected), .partnerPending(partnerPending),
    .pageAck(pageAck), .txValid(txValid), .txPage(txPage));

/* tb/anm_partner.sv */
// Link partner model: accepts each transmitted page, promptly or slowly.
// Assumes the formatter holds txPage until pageAck is seen.
module anm_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Page exchange
    input wire logic txValid,
    input wire logic [15:0] txPage,
    input wire logic slow,
    output logic pageAck,
    output logic [2:0] unfLeft
);
    logic [1:0] waitCnt;
    // One-cycle ack with a gap after it, since the next page lands a cycle later
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pageAck <= 1'b0;
            waitCnt <= 2'h0;
            unfLeft <= 3'h0;
        end else if (pageAck || !txValid) begin
            pageAck <= 1'b0;
        end else if (waitCnt != 2'h0) begin
            waitCnt <= waitCnt - 2'h1;
        end else begin
            pageAck <= 1'b1;
            waitCnt <= slow ? 2'($urandom) : 2'h0;
            // Message code decides how many unformatted pages follow
            if (txPage[13]) begin
                unfLeft <= (txPage[10:0] == 11'h004) ? 3'h1 :
                    (txPage[10:0] == 11'h005 || txPage[10:0] == 11'h006) ? 3'h4 : 3'h0;
            end else if (unfLeft != 3'h0) begin
                unfLeft <= unfLeft - 3'h1;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the message formatter with a partner model.
// Assumes the checker is bound from its own file.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, msgReq, partnerPending, rxValid, userCodeBit, moreAfter, slow;
    logic [4:0] baseSelector, localTech, partnerTech;
    logic [10:0] baseAbility, msgCode, faultCode, userCodeExtra;
    logic [23:0] orgId;
    logic [31:0] phyId;
    logic [8:0] userCodeLow;
    logic [15:0] rxPage, basePage, txPage;
    logic baseSelectorOk, msgReady, msgRejected, txValid, pageAck, rxBadCode, bestValid;
    logic [1:0] rxUnfExpect;
    logic [2:0] bestTech, unfLeft;
    int errors, cmp_count;
    anm_formatter i_anm_formatter (.clk(clk), .rst(rst), .baseSelector(baseSelector),
        .baseAbility(baseAbility), .baseSelectorOk(baseSelectorOk), .basePage(basePage),
        .msgReq(msgReq), .msgCode(msgCode), .faultCode(faultCode), .orgId(orgId),
        .phyId(phyId), .userCodeLow(userCodeLow), .userCodeExtra(userCodeExtra),
        .userCodeBit(userCodeBit), .moreAfter(moreAfter), .msgReady(msgReady),
        .msgRejected(msgRejected), .partnerPending(partnerPending), .pageAck(pageAck),
        .txValid(txValid), .txPage(txPage), .rxPage(rxPage), .rxValid(rxValid),
        .rxBadCode(rxBadCode), .rxUnfExpect(rxUnfExpect), .localTech(localTech),
        .partnerTech(partnerTech), .bestTech(bestTech), .bestValid(bestValid));
    anm_partner i_anm_partner (.clk(clk), .rst(rst), .txValid(txValid), .txPage(txPage),
        .slow(slow), .pageAck(pageAck), .unfLeft(unfLeft));
    // ==========================================================
    // Clock, compare and close
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares=%0d mismatches=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded wait for the partner's ack; a hang ends the run
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pageAck !== 1'b1 && n < 20);
        if (pageAck !== 1'b1) begin
            errors++;
            finish_test();
        end
    endtask
    function automatic logic [15:0] best(input logic [4:0] m);
        for (int b = 4; b >= 0; b--) begin
            if (m[b]) return {12'h0, 1'b1, 3'(b)};
        end
        return {12'h0, 1'b0, anm_pkg::TECH_NONE};
    endfunction
    function automatic logic [10:0] unf_code(input logic [10:0] c, input int i);
        logic [10:0] t[4];
        if (c == anm_pkg::MSG_REMOTE_FAULT) return faultCode;
        if (c == anm_pkg::MSG_ORG_ID) t = '{orgId[23:13], orgId[12:2],
            {orgId[1:0], userCodeLow}, userCodeExtra};
        else t = '{phyId[31:21], phyId[20:10], {phyId[9:0], userCodeBit}, userCodeExtra};
        return t[i];
    endfunction
    // Message then its unformatted pages; toggle bit masked, the checker owns it
    task automatic send(input logic [10:0] c);
        int n;
        n = (c == 11'h004) ? 1 : (c == 11'h005 || c == 11'h006) ? 4 : 0;
        @(posedge clk);
        {orgId, userCodeLow, userCodeBit, moreAfter} <= {3'($urandom), $urandom};
        {phyId, faultCode, userCodeExtra} <= {$urandom, 22'($urandom)};
        msgReq <= 1'b1;
        msgCode <= c;
        @(posedge clk);
        msgReq <= 1'b0;
        #1;
        chk(txPage & 16'hf7ff, {n > 0 || moreAfter, 4'b0100, c});
        chk({15'h0, msgReady}, 16'h0000);
        for (int i = 0; i < n; i++) begin
            wait_ack();
            #1;
            chk(txPage & 16'hf7ff, {i < n - 1 || moreAfter, 4'b0000, unf_code(c, i)});
        end
        wait_ack();
        #1;
        chk({11'h0, msgReady, unfLeft, txValid}, 16'h0010);
    endtask
    task automatic reject(input logic [10:0] c);
        @(posedge clk);
        msgReq <= 1'b1;
        msgCode <= c;
        @(posedge clk);
        msgReq <= 1'b0;
        #1;
        chk({14'h0, msgRejected, txValid}, 16'h0002);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst, msgReq, partnerPending, rxValid, slow} = 5'h10;
        {baseSelector, baseAbility, localTech, partnerTech, rxPage} = '0;
        {msgCode, faultCode, userCodeExtra, orgId, phyId, userCodeLow} = '0;
        {userCodeBit, moreAfter} = 2'h0;
        void'($urandom(77));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            baseSelector <= (i < 32) ? 5'(i) : 5'($urandom);
            baseAbility <= 11'($urandom);
            {localTech, partnerTech} <= (i == 0) ? 10'h3ff : 10'($urandom);
            #1;
            chk(basePage, {baseAbility, 5'h01});
            chk({15'h0, baseSelectorOk}, {15'h0, baseSelector == 5'h01});
            chk({12'h0, bestValid, bestTech}, best(localTech & partnerTech));
        end
        $display("base page and priority test done");
        for (int r = 0; r < 4; r++) begin
            slow <= r[0];
            for (int c = 1; c <= 10; c++) send(11'(c));
        end
        $display("message page test done");
        reject(11'h000);
        reject(11'h7ff);
        reject(11'h00b);
        for (int i = 0; i < 6; i++) reject(11'h00b + 11'($urandom % 2036));
        $display("refusal test done");
        @(posedge clk);
        partnerPending <= 1'b1;
        @(posedge clk);
        partnerPending <= 1'b0;
        #1;
        chk(txPage & 16'hf7ff, 16'h2001);
        wait_ack();
        $display("null page test done");
        @(posedge clk);
        rxPage <= 16'h2000;
        rxValid <= 1'b1;
        @(posedge clk);
        rxPage <= 16'h2006;
        #1;
        chk({15'h0, rxBadCode}, 16'h0001);
        @(posedge clk);
        rxPage <= 16'h0123;
        #1;
        chk({13'h0, rxBadCode, rxUnfExpect}, 16'h0003);
        // Unformatted pages count the expectation down
        for (int k = 3; k >= 1; k--) begin
            @(posedge clk);
            if (k == 1) rxValid <= 1'b0;
            #1;
            chk({14'h0, rxUnfExpect}, 16'(k));
        end
        $display("receive check test done");
        finish_test();
    end
endmodule
